// ===== isr_host_model.sv
// Host controller model that issues status commands and gathers replies
`timescale 1ns/1ns
module isr_host_model (
    input wire logic core_clk_in,
    input wire logic cmd_ready_in,
    input wire logic resp_valid_in,
    input wire logic [15:0] resp_data_in,
    input wire logic resp_last_in,
    output logic cmd_valid_out,
    output isr_pkg::isr_cmd_t cmd_op_out,
    output logic [15:0] cmd_data_out
);
    import isr_pkg::*;
    logic [15:0] words[$];
    int lat;
    logic got_last;

    initial begin
        cmd_valid_out = 1'b0;
        cmd_op_out = ISR_CMD_NOP;
        cmd_data_out = 16'h0000;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Request held until taken or dropped after 200 waiting edges; idle edge before next one avoids double drive
    task automatic send(input isr_cmd_t op, input logic [15:0] d);
        int n;
        n = 0;
        @(posedge core_clk_in);
        cmd_valid_out <= 1'b1;
        cmd_op_out <= op;
        cmd_data_out <= d;
        @(posedge core_clk_in);
        while (cmd_ready_in !== 1'b1 && n < 200) begin
            @(posedge core_clk_in);
            n++;
        end
        cmd_valid_out <= 1'b0;
    endtask

    // Latency counted from the taking edge; no reply leaves words empty
    task automatic query(input isr_cmd_t op);
        words.delete();
        lat = 0;
        got_last = 1'b0;
        send(op, 16'h0000);
        do begin
            @(posedge core_clk_in);
            lat++;
        end while (resp_valid_in !== 1'b1 && lat < 8);
        while (resp_valid_in === 1'b1) begin
            words.push_back(resp_data_in);
            if (resp_last_in === 1'b1) begin
                got_last = 1'b1;
                break;
            end
            @(posedge core_clk_in);
        end
    endtask
endmodule

// ===== isr_params.svh
// Field positions, masks, sizes and reply values of the status registers
`ifndef ISR_PARAMS_SVH
`define ISR_PARAMS_SVH
`define ISR_QUES_VOLT_BIT 0
`define ISR_QUES_TEMP_BIT 4
`define ISR_QUES_OHMS_BIT 9
`define ISR_QUES_MASK 16'h0211
`define ISR_OPER_SETTLED_BIT 8
`define ISR_OPER_MASK 16'h0100
`define ISR_STD_OPC_BIT 0
`define ISR_STD_MASK 8'hbd
`define ISR_ERR_DEPTH 20
`define ISR_ERR_CHARS 80
`define ISR_OPC_REPLY 16'h0001
`define ISR_EMPTY_REPLY 16'h0000
`endif

// ===== isr_pkg.sv
// Types shared by the status register model
package isr_pkg;
    typedef enum logic [4:0] {
        ISR_CMD_NOP         = 5'h00,
        ISR_CMD_CLS         = 5'h01,
        ISR_CMD_PRESET      = 5'h02,
        ISR_CMD_QUES_COND_Q = 5'h03,
        ISR_CMD_QUES_EN_W   = 5'h04,
        ISR_CMD_QUES_EN_Q   = 5'h05,
        ISR_CMD_QUES_EVT_Q  = 5'h06,
        ISR_CMD_OPER_COND_Q = 5'h07,
        ISR_CMD_OPER_EN_W   = 5'h08,
        ISR_CMD_OPER_EN_Q   = 5'h09,
        ISR_CMD_OPER_EVT_Q  = 5'h0a,
        ISR_CMD_STD_EN_W    = 5'h0b,
        ISR_CMD_STD_EN_Q    = 5'h0c,
        ISR_CMD_STD_EVT_Q   = 5'h0d,
        ISR_CMD_OPC         = 5'h0e,
        ISR_CMD_OPC_Q       = 5'h0f,
        ISR_CMD_ERR_Q       = 5'h10
    } isr_cmd_t;

    typedef enum logic [1:0] {
        ISR_ST_IDLE = 2'b01,
        ISR_ST_ERR  = 2'b10
    } isr_state_t;
endpackage

// ===== isr_status_regs.sv
// Command-driven status register bank with error queue
`timescale 1ns/1ns
`include "isr_params.svh"
module isr_status_regs #(
    parameter int ERR_DEPTH = `ISR_ERR_DEPTH,
    parameter int ERR_CHARS = `ISR_ERR_CHARS
) (
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic power_up_in,
    input wire logic power_on_clear_setting_in,
    input wire logic cmd_valid_in,
    input wire isr_pkg::isr_cmd_t cmd_op_in,
    input wire logic [15:0] cmd_data_in,
    input wire logic meas_valid_in,
    input wire logic filter_en_in,
    input wire logic filter_settled_in,
    input wire logic volt_ovld_in,
    input wire logic temp_ovld_in,
    input wire logic ohms_ovld_in,
    input wire logic [7:0] std_evt_set_in,
    input wire logic err_char_valid_in,
    input wire logic [7:0] err_char_in,
    input wire logic err_char_last_in,
    output logic cmd_ready_out,
    output logic resp_valid_out,
    output logic [15:0] resp_data_out,
    output logic resp_last_out,
    output logic ques_sum_out,
    output logic oper_sum_out,
    output logic std_sum_out,
    output logic err_full_out
);
    import isr_pkg::*;

    localparam int MEM_W = $clog2(ERR_DEPTH * ERR_CHARS);
    localparam int SLOT_W = $clog2(ERR_DEPTH);
    localparam int CHAR_W = $clog2(ERR_CHARS + 1);
    localparam int CNT_W = $clog2(ERR_DEPTH + 1);

    isr_state_t state_q;
    logic [15:0] ques_cond_q, ques_evt_q, ques_en_q;
    logic [15:0] oper_cond_q, oper_evt_q, oper_en_q;
    logic [15:0] ques_cond_d, ques_evt_d, ques_en_d;
    logic [15:0] oper_cond_d, oper_evt_d, oper_en_d;
    logic [7:0] std_evt_q, std_en_q, std_evt_d, std_en_d;
    logic cmd_go;
    logic [7:0] err_mem [0:ERR_DEPTH*ERR_CHARS-1];
    logic [CHAR_W-1:0] err_len_q [0:ERR_DEPTH-1];
    logic [SLOT_W-1:0] wr_slot_q, rd_slot_q;
    logic [CHAR_W-1:0] wr_ci_q, rd_ci_q;
    logic [CNT_W-1:0] err_count_q;
    logic wr_open_q, wr_keep_q, wr_keep, push_done, pop_done;
    logic [MEM_W-1:0] wr_addr, rd_addr;

    assign cmd_go = cmd_valid_in && cmd_ready_out;

    function automatic logic [SLOT_W-1:0] slot_inc(input logic [SLOT_W-1:0] s);
        slot_inc = (32'(s) == ERR_DEPTH - 1) ? '0 : s + 1'b1;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Next values of conditions, events and enables
    always_comb begin
        ques_cond_d = ques_cond_q;
        oper_cond_d = oper_cond_q;
        if (meas_valid_in) begin
            ques_cond_d = '0;
            ques_cond_d[`ISR_QUES_VOLT_BIT] = volt_ovld_in;
            ques_cond_d[`ISR_QUES_TEMP_BIT] = temp_ovld_in;
            ques_cond_d[`ISR_QUES_OHMS_BIT] = ohms_ovld_in;
            oper_cond_d = '0;
            oper_cond_d[`ISR_OPER_SETTLED_BIT] = filter_en_in && filter_settled_in;
        end
        // Clears go first, latched rising edges go after so a set is never lost
        ques_evt_d = ques_evt_q;
        oper_evt_d = oper_evt_q;
        std_evt_d = std_evt_q;
        if (cmd_go && (cmd_op_in == ISR_CMD_CLS || cmd_op_in == ISR_CMD_QUES_EVT_Q)) begin
            ques_evt_d = '0;
        end
        if (cmd_go && (cmd_op_in == ISR_CMD_CLS || cmd_op_in == ISR_CMD_OPER_EVT_Q)) begin
            oper_evt_d = '0;
        end
        if (cmd_go && (cmd_op_in == ISR_CMD_CLS || cmd_op_in == ISR_CMD_STD_EVT_Q)) begin
            std_evt_d = '0;
        end
        ques_evt_d = ques_evt_d | (ques_cond_d & ~ques_cond_q & `ISR_QUES_MASK);
        oper_evt_d = oper_evt_d | (oper_cond_d & ~oper_cond_q & `ISR_OPER_MASK);
        std_evt_d = std_evt_d | (std_evt_set_in & `ISR_STD_MASK);
        if (cmd_go && cmd_op_in == ISR_CMD_OPC) begin
            std_evt_d[`ISR_STD_OPC_BIT] = 1'b1;
        end
        ques_en_d = ques_en_q;
        oper_en_d = oper_en_q;
        std_en_d = std_en_q;
        if (power_up_in || (cmd_go && cmd_op_in == ISR_CMD_PRESET)) begin
            ques_en_d = '0;
            oper_en_d = '0;
        end
        if (power_up_in && power_on_clear_setting_in) begin
            std_en_d = '0;
        end
        if (cmd_go && cmd_op_in == ISR_CMD_QUES_EN_W) begin
            ques_en_d = cmd_data_in;
        end
        if (cmd_go && cmd_op_in == ISR_CMD_OPER_EN_W) begin
            oper_en_d = cmd_data_in;
        end
        if (cmd_go && cmd_op_in == ISR_CMD_STD_EN_W) begin
            std_en_d = cmd_data_in[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register bank
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            ques_cond_q <= '0;
            ques_evt_q <= '0;
            ques_en_q <= '0;
            oper_cond_q <= '0;
            oper_evt_q <= '0;
            oper_en_q <= '0;
            std_evt_q <= '0;
            std_en_q <= '0;
        end else begin
            ques_cond_q <= ques_cond_d;
            ques_evt_q <= ques_evt_d;
            ques_en_q <= ques_en_d;
            oper_cond_q <= oper_cond_d;
            oper_evt_q <= oper_evt_d;
            oper_en_q <= oper_en_d;
            std_evt_q <= std_evt_d;
            std_en_q <= std_en_d;
        end
    end

    // Summaries from next values so a clear-status drops them in the same edge
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            ques_sum_out <= 1'b0;
            oper_sum_out <= 1'b0;
            std_sum_out <= 1'b0;
        end else begin
            ques_sum_out <= |(ques_evt_d & ques_en_d);
            oper_sum_out <= |(oper_evt_d & oper_en_d);
            std_sum_out <= |(std_evt_d & std_en_d);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Error queue write side; a whole entry is dropped when the queue is full
    assign wr_keep = wr_open_q ? wr_keep_q : (32'(err_count_q) < ERR_DEPTH);
    assign push_done = err_char_valid_in && err_char_last_in && wr_keep;
    assign wr_addr = MEM_W'(32'(wr_slot_q) * ERR_CHARS + 32'(wr_ci_q));

    always_ff @(posedge core_clk_in) begin
        if (err_char_valid_in && wr_keep && 32'(wr_ci_q) < ERR_CHARS) begin
            err_mem[wr_addr] <= err_char_in;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            wr_open_q <= 1'b0;
            wr_keep_q <= 1'b0;
            wr_ci_q <= '0;
            wr_slot_q <= '0;
        end else if (err_char_valid_in) begin
            wr_open_q <= !err_char_last_in;
            wr_keep_q <= wr_keep;
            // Characters past the limit are truncated
            if (err_char_last_in) begin
                wr_ci_q <= '0;
            end else if (32'(wr_ci_q) < ERR_CHARS) begin
                wr_ci_q <= wr_ci_q + 1'b1;
            end
            if (push_done) begin
                wr_slot_q <= slot_inc(wr_slot_q);
            end
        end
    end

    generate
        for (genvar g = 0; g < ERR_DEPTH; g++) begin : g_len
            always_ff @(posedge core_clk_in) begin
                if (!rst_n_in) begin
                    err_len_q[g] <= '0;
                end else if (push_done && 32'(wr_slot_q) == g) begin
                    err_len_q[g] <= (32'(wr_ci_q) < ERR_CHARS) ? wr_ci_q + 1'b1 : wr_ci_q;
                end
            end
        end
    endgenerate

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            err_count_q <= '0;
            err_full_out <= 1'b0;
        end else begin
            err_count_q <= err_count_q + CNT_W'(push_done) - CNT_W'(pop_done);
            err_full_out <= 32'(err_count_q + CNT_W'(push_done) - CNT_W'(pop_done))
                == ERR_DEPTH;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Command sequencing and responses
    assign rd_addr = MEM_W'(32'(rd_slot_q) * ERR_CHARS + 32'(rd_ci_q));
    assign pop_done = (state_q == ISR_ST_ERR) && (rd_ci_q + 1'b1 == err_len_q[rd_slot_q]);

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            state_q <= ISR_ST_IDLE;
            cmd_ready_out <= 1'b1;
            rd_slot_q <= '0;
            rd_ci_q <= '0;
        end else begin
            case (state_q)
                ISR_ST_IDLE: begin
                    if (cmd_go && cmd_op_in == ISR_CMD_ERR_Q && err_count_q != '0) begin
                        state_q <= ISR_ST_ERR;
                        cmd_ready_out <= 1'b0;
                        rd_ci_q <= '0;
                    end
                end
                ISR_ST_ERR: begin
                    // Oldest entry streams out one character per cycle
                    if (pop_done) begin
                        state_q <= ISR_ST_IDLE;
                        cmd_ready_out <= 1'b1;
                        rd_slot_q <= slot_inc(rd_slot_q);
                    end else begin
                        rd_ci_q <= rd_ci_q + 1'b1;
                    end
                end
                default: begin
                    state_q <= ISR_ST_IDLE;
                    cmd_ready_out <= 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            resp_valid_out <= 1'b0;
            resp_data_out <= '0;
            resp_last_out <= 1'b0;
        end else begin
            resp_valid_out <= 1'b0;
            resp_last_out <= 1'b0;
            if (state_q == ISR_ST_ERR) begin
                resp_valid_out <= 1'b1;
                resp_data_out <= {8'h00, err_mem[rd_addr]};
                resp_last_out <= pop_done;
            end else if (cmd_go) begin
                resp_valid_out <= 1'b1;
                resp_last_out <= 1'b1;
                case (cmd_op_in)
                    ISR_CMD_QUES_COND_Q: resp_data_out <= ques_cond_q;
                    ISR_CMD_QUES_EN_Q: resp_data_out <= ques_en_q;
                    ISR_CMD_QUES_EVT_Q: resp_data_out <= ques_evt_q;
                    ISR_CMD_OPER_COND_Q: resp_data_out <= oper_cond_q;
                    ISR_CMD_OPER_EN_Q: resp_data_out <= oper_en_q;
                    ISR_CMD_OPER_EVT_Q: resp_data_out <= oper_evt_q;
                    ISR_CMD_STD_EN_Q: resp_data_out <= {8'h00, std_en_q};
                    ISR_CMD_STD_EVT_Q: resp_data_out <= {8'h00, std_evt_q};
                    ISR_CMD_OPC_Q: resp_data_out <= `ISR_OPC_REPLY;
                    ISR_CMD_ERR_Q: begin
                        // Only an empty queue answers here; otherwise streaming starts
                        resp_valid_out <= (err_count_q == '0);
                        resp_data_out <= `ISR_EMPTY_REPLY;
                    end
                    default: begin
                        resp_valid_out <= 1'b0;
                        resp_last_out <= 1'b0;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_cmd(isr_cmd_t c);
        cmd_go && cmd_op_in == c;
    endsequence

    property p_ques_evt_clr;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        s_cmd(ISR_CMD_QUES_EVT_Q) ##0 !meas_valid_in |=> ques_evt_q == '0;
    endproperty
    a_ques_evt_clr: assert property (p_ques_evt_clr) else $error("ques event not cleared");

    property p_preset;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        s_cmd(ISR_CMD_PRESET) |=> ques_en_q == '0 && oper_en_q == '0;
    endproperty
    a_preset: assert property (p_preset) else $error("preset left enables");

    property p_oper_only_bit8;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        ((oper_evt_q | oper_cond_q) & ~`ISR_OPER_MASK) == '0;
    endproperty
    a_oper_only_bit8: assert property (p_oper_only_bit8) else $error("stray oper bit");

    property p_oper_latch;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        $rose(oper_cond_q[`ISR_OPER_SETTLED_BIT]) |-> oper_evt_q[`ISR_OPER_SETTLED_BIT];
    endproperty
    a_oper_latch: assert property (p_oper_latch) else $error("settle not latched");

    property p_oper_sticky;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        oper_evt_q[`ISR_OPER_SETTLED_BIT]
        && !(cmd_go && (cmd_op_in == ISR_CMD_CLS || cmd_op_in == ISR_CMD_OPER_EVT_Q))
        |=> oper_evt_q[`ISR_OPER_SETTLED_BIT];
    endproperty
    a_oper_sticky: assert property (p_oper_sticky) else $error("settle bit lost");

    property p_cls_keeps_en;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        s_cmd(ISR_CMD_CLS) ##0 !power_up_in ##0 !meas_valid_in ##0 std_evt_set_in == 8'h00
        |=> $stable(ques_en_q) && $stable(oper_en_q) && $stable(std_en_q)
        && !ques_sum_out && !oper_sum_out && !std_sum_out;
    endproperty
    a_cls_keeps_en: assert property (p_cls_keeps_en) else $error("clear touched enables");

    property p_opc;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        s_cmd(ISR_CMD_OPC) |=> std_evt_q[`ISR_STD_OPC_BIT];
    endproperty
    a_opc: assert property (p_opc) else $error("opc bit not set");

    property p_opc_q;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        s_cmd(ISR_CMD_OPC_Q) |=> resp_valid_out && resp_data_out == `ISR_OPC_REPLY;
    endproperty
    a_opc_q: assert property (p_opc_q) else $error("opc query reply wrong");

    property p_err_bound;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        32'(err_count_q) <= ERR_DEPTH && (state_q != ISR_ST_ERR || 32'(rd_ci_q) < ERR_CHARS);
    endproperty
    a_err_bound: assert property (p_err_bound) else $error("error queue overrun");

    property p_psc_keep;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        power_up_in && !power_on_clear_setting_in
        && !(cmd_go && cmd_op_in == ISR_CMD_STD_EN_W)
        |=> $stable(std_en_q);
    endproperty
    a_psc_keep: assert property (p_psc_keep) else $error("std enable lost");
endmodule

// ===== isr_status_regs_test.sv
// Self-checking testbench of the status register bank
`timescale 1ns/1ns
module isr_status_regs_test;
    import isr_pkg::*;
    logic clk, rst_n, pwr, poc, cmd_valid, mv, fe, fs, vo, te, oh;
    logic ecv, ecl, ready, rv, rl, qs, os, ss, full;
    logic [7:0] std_set, ech;
    logic [15:0] cmd_data, rd;
    isr_cmd_t cmd_op;
    int mismatches, num_checks;

    isr_status_regs dut (.core_clk_in(clk), .rst_n_in(rst_n), .power_up_in(pwr),
        .power_on_clear_setting_in(poc), .cmd_valid_in(cmd_valid), .cmd_op_in(cmd_op),
        .cmd_data_in(cmd_data), .meas_valid_in(mv), .filter_en_in(fe),
        .filter_settled_in(fs), .volt_ovld_in(vo), .temp_ovld_in(te), .ohms_ovld_in(oh),
        .std_evt_set_in(std_set), .err_char_valid_in(ecv), .err_char_in(ech),
        .err_char_last_in(ecl), .cmd_ready_out(ready), .resp_valid_out(rv),
        .resp_data_out(rd), .resp_last_out(rl), .ques_sum_out(qs), .oper_sum_out(os),
        .std_sum_out(ss), .err_full_out(full));

    isr_host_model host (.core_clk_in(clk), .cmd_ready_in(ready), .resp_valid_in(rv),
        .resp_data_in(rd), .resp_last_in(rl), .cmd_valid_out(cmd_valid),
        .cmd_op_out(cmd_op), .cmd_data_out(cmd_data));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        if (mismatches == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Plain query: one word, one cycle after the taking edge
    task automatic expq(input isr_cmd_t op, input logic [15:0] exp);
        host.query(op);
        chk(host.words[0], exp);
        chk(16'(host.lat), 16'h0001);
        chk(16'(host.got_last), 16'h0001);
    endtask

    task automatic meas(input logic f_en, f_st, v, t, o);
        @(posedge clk);
        mv <= 1'b1;
        fe <= f_en;
        fs <= f_st;
        vo <= v;
        te <= t;
        oh <= o;
        @(posedge clk);
        mv <= 1'b0;
    endtask

    task automatic std_pulse(input logic [7:0] b);
        @(posedge clk);
        std_set <= b;
        @(posedge clk);
        std_set <= 8'h00;
    endtask

    task automatic power(input logic setting);
        @(posedge clk);
        pwr <= 1'b1;
        poc <= setting;
        @(posedge clk);
        pwr <= 1'b0;
    endtask

    task automatic push_err(input int len, input logic [7:0] base);
        for (int i = 0; i < len; i++) begin
            @(posedge clk);
            ecv <= 1'b1;
            ech <= base + i[7:0];
            ecl <= (i == len - 1);
        end
        @(posedge clk);
        ecv <= 1'b0;
        ecl <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12000) @(posedge clk);
        mismatches++;
        print_verdict();
    end

    initial begin
        {rst_n, pwr, poc, mv, fe, fs, vo, te, oh, ecv, ecl} = '0;
        std_set = 8'h00;
        ech = 8'h00;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        expq(ISR_CMD_QUES_EN_Q, 16'h0000);
        expq(ISR_CMD_OPER_EN_Q, 16'h0000);
        host.send(ISR_CMD_QUES_EN_W, 16'h0211);
        expq(ISR_CMD_QUES_EN_Q, 16'h0211);
        host.send(ISR_CMD_OPER_EN_W, 16'h0100);
        expq(ISR_CMD_OPER_EN_Q, 16'h0100);
        host.send(ISR_CMD_STD_EN_W, 16'h0021);
        expq(ISR_CMD_STD_EN_Q, 16'h0021);
        // Settled without filter enabled must not show
        meas(1'b0, 1'b1, 1'b1, 1'b1, 1'b1);
        expq(ISR_CMD_OPER_COND_Q, 16'h0000);
        expq(ISR_CMD_QUES_COND_Q, 16'h0211);
        expq(ISR_CMD_QUES_COND_Q, 16'h0211);
        chk(qs, 1'b1);
        chk(os, 1'b0);
        expq(ISR_CMD_QUES_EVT_Q, 16'h0211);
        expq(ISR_CMD_QUES_EVT_Q, 16'h0000);
        chk(qs, 1'b0);
        meas(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
        expq(ISR_CMD_OPER_COND_Q, 16'h0100);
        chk(os, 1'b1);
        meas(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        expq(ISR_CMD_OPER_COND_Q, 16'h0000);
        expq(ISR_CMD_OPER_EVT_Q, 16'h0100);
        expq(ISR_CMD_OPER_EVT_Q, 16'h0000);
        host.send(ISR_CMD_OPC, 16'h0000);
        expq(ISR_CMD_STD_EVT_Q, 16'h0001);
        expq(ISR_CMD_STD_EVT_Q, 16'h0000);
        expq(ISR_CMD_OPC_Q, 16'h0001);
        meas(1'b1, 1'b1, 1'b1, 1'b1, 1'b1);
        std_pulse(8'hff);
        @(posedge clk);
        chk({qs, os, ss}, 3'b111);
        expq(ISR_CMD_STD_EVT_Q, 16'h00bd);
        std_pulse(8'h21);
        host.send(ISR_CMD_CLS, 16'h0000);
        @(posedge clk);
        chk({qs, os, ss}, 3'b000);
        expq(ISR_CMD_QUES_EVT_Q, 16'h0000);
        expq(ISR_CMD_OPER_EVT_Q, 16'h0000);
        expq(ISR_CMD_STD_EVT_Q, 16'h0000);
        expq(ISR_CMD_QUES_EN_Q, 16'h0211);
        host.send(ISR_CMD_QUES_EN_W, 16'h0000);
        expq(ISR_CMD_QUES_EN_Q, 16'h0000);
        host.send(ISR_CMD_OPER_EN_W, 16'h0000);
        expq(ISR_CMD_OPER_EN_Q, 16'h0000);
        host.send(ISR_CMD_QUES_EN_W, 16'h0211);
        host.send(ISR_CMD_OPER_EN_W, 16'h0100);
        host.send(ISR_CMD_PRESET, 16'h0000);
        expq(ISR_CMD_QUES_EN_Q, 16'h0000);
        expq(ISR_CMD_OPER_EN_Q, 16'h0000);
        host.send(ISR_CMD_QUES_EN_W, 16'h0211);
        host.send(ISR_CMD_OPER_EN_W, 16'h0100);
        power(1'b0);
        expq(ISR_CMD_QUES_EN_Q, 16'h0000);
        expq(ISR_CMD_OPER_EN_Q, 16'h0000);
        expq(ISR_CMD_STD_EN_Q, 16'h0021);
        power(1'b1);
        expq(ISR_CMD_STD_EN_Q, 16'h0000);
        // Error queue: empty reply, overlong entry, fill, overflow, order
        expq(ISR_CMD_ERR_Q, 16'h0000);
        push_err(81, 8'h20);
        for (int k = 0; k < 19; k++) push_err(1, 8'h40 + k[7:0]);
        @(posedge clk);
        chk(full, 1'b1);
        push_err(1, 8'hee);
        host.query(ISR_CMD_ERR_Q);
        chk(16'(host.words.size()), 16'd80);
        chk(16'(host.got_last), 16'h0001);
        chk(host.words[79], 16'h006f);
        chk(full, 1'b0);
        for (int k = 0; k < 19; k++) begin
            host.query(ISR_CMD_ERR_Q);
            chk(host.words[0], 16'h0040 + 16'(k));
        end
        expq(ISR_CMD_ERR_Q, 16'h0000);
        print_verdict();
    end
endmodule
